// >>> rtl/ads_consts.svh
/*
  Constants shared by both ends of the converter's two-wire serial port.
  Assumes a 50 ns system clock; included by its bare name.
*/
`ifndef ADS_CONSTS_SVH
`define ADS_CONSTS_SVH

// System clock period and derived counts
`define ADS_CLK_NS 50
`define ADS_POR_NS 4000000
`define ADS_POR_W 17
`define ADS_POR_CYC (`ADS_POR_NS / `ADS_CLK_NS)
// Quarter of a standard-mode bit period (10 us per bit, 100 kbit/s)
`define ADS_QTR_NS 2500
`define ADS_QTR_W 6
`define ADS_QTR_CYC (`ADS_QTR_NS / `ADS_CLK_NS)

// Slave address of the converter, arbitrary value
`define ADS_DEV_ADDR 7'h14
// Configuration after internal reset: inputs zero/one, 50/60 Hz, 1x, gain 1
`define ADS_CFG_RST 16'hA000
// Enable preamble that makes a written channel word take effect
`define ADS_EN_CODE 3'h5
// Result formatting
`define ADS_OVR_CODE 18'h30000
`define ADS_UNR_CODE 18'h0FFFF
`define ADS_PAD_ZERO 6'h00
// Framing counts
`define ADS_BIT_LAST 3'h7
`define ADS_ACK_SLOT 4'h8
`define ADS_RD_LAST 2'h2
`define ADS_WR_MAX 2'h2
`define ADS_LEN_ADDR 2'h0
`define ADS_LEN_ONE 2'h1
// Synchroniser reset: supply low, clock and data lines high
`define ADS_SYNC_RST 3'h3

`endif

// >>> rtl/ads_pkg.sv
/*
  Types for both ends of the converter's two-wire serial port.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ads_pkg;

  // Converter end: position within a bus transfer
  typedef enum logic [3:0] {
    DS_IDLE, DS_ADDR, DS_ADDR_DEC, DS_A_ACK, DS_WR, DS_W_DEC, DS_W_ACK,
    DS_RD, DS_RD_END, DS_RD_MACK, DS_RD_NEXT, DS_IGNORE
  } ads_dev_state_type;

  // Controller end: bus sequence being generated
  typedef enum logic [2:0] {
    HS_IDLE, HS_HELD, HS_START, HS_BIT, HS_STOP
  } ads_host_state_type;

endpackage : ads_pkg

// >>> rtl/ads_if.sv
/*
  Two-wire bus between the controller end and the converter end.
  Resolves the open-drain data line with an implied pull-up; the clock
  line is driven by the controller alone.
*/
`timescale 1ns/10ps
interface ads_if;
  logic scl;
  logic sda;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;

  // Pull-up holds the line high unless an enabled driver pulls low
  assign sda = ((!dev_sda_oe_n && !dev_sda_o) ||
                (!host_sda_oe_n && !host_sda_o)) ? 1'b0 : 1'b1;

  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
  modport host (output scl, input sda, output host_sda_o,
                output host_sda_oe_n);
endinterface : ads_if

// >>> rtl/ads_dev_end.sv
/*
  Converter end of the two-wire serial port: slave protocol engine,
  supply-triggered internal reset, configuration word and result shifter.
  Assumes the conversion core pulses conv_done_i with result_i, over_i and
  under_i valid, and that supply_ok_i comes from an analog comparator.
*/
// The plain strobed port and the placing of the registers were left to the implementer.
// Overview of operation
// - Low supply holds block in internal reset
// - Supply return gives 4 ms clearing reset
// - First conversion uses reset default configuration
// - First I/O cycle after the first conversion ends accepts configuration
// - Overrange and underrange get distinct result codes
// - Data line only pulled low or released
// - Bus runs up to 100 or 400 kbit/s
// - Converter is slave only, never clocks
// - Clock line input, data line bidirectional
// - Addressed converter takes configuration or gives result
// - Master makes Start: data falls, clock high
// - Master makes Stop: data rises, clock high
// - Bus busy from Start until Stop
// - Repeated Start handled like Start, stays busy
// - Write then read within one transaction
// - Unit is eight data bits plus acknowledge
// - Master releases data in ninth clock
// - Acknowledge pulls low, refusal leaves released
// - Data changes only while clock low
// - Seven-bit address then direction bit selects
// - Converting device refuses its address
// - Stop after write starts conversion; full read too
// - Result is 24 bits, changed on falling edges
`timescale 1ns/10ps
`include "ads_consts.svh"
module ads_dev_end
  import ads_pkg::*;
#(
  parameter logic [`ADS_POR_W-1:0] POR_CYCLES = `ADS_POR_W'(`ADS_POR_CYC)
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  ads_if.dev bus,
  input wire logic supply_ok_i,
  input wire logic conv_done_i,
  input wire logic [16:0] result_i,
  input wire logic over_i,
  input wire logic under_i,
  output logic conv_start_o,
  output logic [15:0] cfg_o,
  output logic busy_o,
  output logic por_o
);

  logic [2:0] s1_reg;
  logic [2:0] s2_reg;
  logic [2:0] s3_reg;
  logic [2:0] flt_reg;
  logic [2:0] flt_next;
  logic [`ADS_POR_W-1:0] por_cnt_reg;
  logic por_reg;
  logic por_end;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic sda_in;
  logic kick;
  ads_dev_state_type state_reg;
  logic [2:0] cnt_reg;
  logic [7:0] sh_reg;
  logic match_reg;
  logic rw_reg;
  logic [23:0] tx_reg;
  logic [23:0] hold_reg;
  logic sda_oe_n_reg;
  logic sda_o_reg;
  logic [1:0] wr_cnt_reg;
  logic [1:0] rd_cnt_reg;
  logic rd_started_reg;
  logic [7:0] wr_hi_reg;
  logic [7:0] wr_lo_reg;
  logic [15:0] cfg_reg;
  logic busy_reg;
  logic conv_start_reg;

  // Three-stage sampling of data, clock and supply; bit 0 data, 1 clock
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_reg <= `ADS_SYNC_RST;
      s2_reg <= `ADS_SYNC_RST;
      s3_reg <= `ADS_SYNC_RST;
      flt_reg <= `ADS_SYNC_RST;
    end else begin
      s1_reg <= {supply_ok_i, bus.scl, bus.sda};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      flt_reg <= flt_next;
    end
  end

  // A change is accepted only once the last two stages agree
  assign flt_next = (~(s2_reg ^ s3_reg) & s3_reg) |
                    ((s2_reg ^ s3_reg) & flt_reg);
  assign sda_in = flt_reg[0];
  assign scl_rise = flt_next[1] & ~flt_reg[1];
  assign scl_fall = ~flt_next[1] & flt_reg[1];
  // Conditions need the clock high on both sides of the data edge
  assign start_det = ~flt_next[0] & flt_reg[0] & flt_next[1] & flt_reg[1];
  assign stop_det = flt_next[0] & ~flt_reg[0] & flt_next[1] & flt_reg[1];

  // Internal reset held while supply is low, then timed after its return
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      por_cnt_reg <= '0;
      por_reg <= 1'b1;
    end else if (!flt_reg[2]) begin
      por_cnt_reg <= '0;
      por_reg <= 1'b1;
    end else if (por_reg) begin
      if (por_end) begin
        por_reg <= 1'b0;
      end else begin
        por_cnt_reg <= por_cnt_reg + 1'b1;
      end
    end
  end

  assign por_end = por_reg && flt_reg[2] && (por_cnt_reg == POR_CYCLES - 1'b1);

  // Conversion starts after a write, an unfinished read or a full read
  assign kick = (stop_det && ((wr_cnt_reg != '0) || rd_started_reg)) ||
                (state_reg == DS_RD_MACK && scl_rise &&
                 rd_cnt_reg == `ADS_RD_LAST);

  // Slave protocol engine; never drives the clock and only pulls data low
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= DS_IDLE;
      cnt_reg <= '0;
      sh_reg <= '0;
      match_reg <= 1'b0;
      rw_reg <= 1'b0;
      tx_reg <= '0;
      sda_oe_n_reg <= 1'b1;
      wr_cnt_reg <= '0;
      rd_cnt_reg <= '0;
      rd_started_reg <= 1'b0;
      wr_hi_reg <= '0;
      wr_lo_reg <= '0;
    end else if (por_reg) begin
      state_reg <= DS_IDLE;
      cnt_reg <= '0;
      sh_reg <= '0;
      match_reg <= 1'b0;
      rw_reg <= 1'b0;
      tx_reg <= '0;
      sda_oe_n_reg <= 1'b1;
      wr_cnt_reg <= '0;
      rd_cnt_reg <= '0;
      rd_started_reg <= 1'b0;
      wr_hi_reg <= '0;
      wr_lo_reg <= '0;
    end else if (start_det) begin
      state_reg <= DS_ADDR;
      cnt_reg <= '0;
      sda_oe_n_reg <= 1'b1;
      rd_cnt_reg <= '0;
      if (kick) begin
        rd_started_reg <= 1'b0;
      end
    end else if (stop_det) begin
      state_reg <= DS_IDLE;
      sda_oe_n_reg <= 1'b1;
      wr_cnt_reg <= '0;
      rd_started_reg <= 1'b0;
    end else begin
      case (state_reg)
        DS_ADDR: begin
          if (scl_rise) begin
            sh_reg <= {sh_reg[6:0], sda_in};
            cnt_reg <= cnt_reg + 1'b1;
            if (cnt_reg == `ADS_BIT_LAST) begin
              match_reg <= (sh_reg[6:0] == `ADS_DEV_ADDR);
              rw_reg <= sda_in;
              state_reg <= DS_ADDR_DEC;
            end
          end
        end
        DS_ADDR_DEC: begin
          if (scl_fall) begin
            if (match_reg && !busy_reg) begin
              sda_oe_n_reg <= 1'b0;
              state_reg <= DS_A_ACK;
              if (rw_reg) begin
                tx_reg <= hold_reg;
                rd_started_reg <= 1'b1;
              end
            end else begin
              state_reg <= DS_IGNORE;
            end
          end
        end
        DS_A_ACK: begin
          if (scl_fall) begin
            cnt_reg <= '0;
            if (rw_reg) begin
              sda_oe_n_reg <= tx_reg[23];
              tx_reg <= {tx_reg[22:0], 1'b0};
              state_reg <= DS_RD;
            end else begin
              sda_oe_n_reg <= 1'b1;
              state_reg <= DS_WR;
            end
          end
        end
        DS_WR: begin
          if (scl_rise) begin
            sh_reg <= {sh_reg[6:0], sda_in};
            cnt_reg <= cnt_reg + 1'b1;
            if (cnt_reg == `ADS_BIT_LAST) begin
              if (wr_cnt_reg == `ADS_WR_MAX) begin
                state_reg <= DS_IGNORE;
              end else begin
                if (wr_cnt_reg == '0) begin
                  wr_hi_reg <= {sh_reg[6:0], sda_in};
                end else begin
                  wr_lo_reg <= {sh_reg[6:0], sda_in};
                end
                wr_cnt_reg <= wr_cnt_reg + 1'b1;
                state_reg <= DS_W_DEC;
              end
            end
          end
        end
        DS_W_DEC: begin
          if (scl_fall) begin
            sda_oe_n_reg <= 1'b0;
            state_reg <= DS_W_ACK;
          end
        end
        DS_W_ACK: begin
          if (scl_fall) begin
            sda_oe_n_reg <= 1'b1;
            cnt_reg <= '0;
            state_reg <= DS_WR;
          end
        end
        DS_RD: begin
          if (scl_rise) begin
            cnt_reg <= cnt_reg + 1'b1;
            if (cnt_reg == `ADS_BIT_LAST) begin
              state_reg <= DS_RD_END;
            end
          end else if (scl_fall) begin
            sda_oe_n_reg <= tx_reg[23];
            tx_reg <= {tx_reg[22:0], 1'b0};
          end
        end
        DS_RD_END: begin
          if (scl_fall) begin
            sda_oe_n_reg <= 1'b1; // Let the master answer
            state_reg <= DS_RD_MACK;
          end
        end
        DS_RD_MACK: begin
          if (scl_rise) begin
            rd_cnt_reg <= rd_cnt_reg + 1'b1;
            if (rd_cnt_reg == `ADS_RD_LAST) begin
              rd_started_reg <= 1'b0;
              state_reg <= DS_IGNORE;
            end else if (!sda_in) begin
              state_reg <= DS_RD_NEXT;
            end else begin
              state_reg <= DS_IGNORE;
            end
          end
        end
        DS_RD_NEXT: begin
          if (scl_fall) begin
            sda_oe_n_reg <= tx_reg[23];
            tx_reg <= {tx_reg[22:0], 1'b0};
            cnt_reg <= '0;
            state_reg <= DS_RD;
          end
        end
        DS_IDLE, DS_IGNORE: begin
          sda_oe_n_reg <= 1'b1;
        end
        default: begin
          state_reg <= DS_IDLE;
          sda_oe_n_reg <= 1'b1;
        end
      endcase
    end
  end

  // Data output level is always low; only the enable moves
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sda_o_reg <= 1'b0;
    end else begin
      sda_o_reg <= 1'b0;
    end
  end

  // Configuration: defaults at reset, written words applied at the kick if the first word carries the enable code
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_reg <= `ADS_CFG_RST;
    end else if (por_reg) begin
      cfg_reg <= `ADS_CFG_RST;
    end else if (kick && wr_cnt_reg != '0 &&
                 wr_hi_reg[7:5] == `ADS_EN_CODE) begin
      cfg_reg <= {wr_hi_reg, (wr_cnt_reg == `ADS_LEN_ONE) ?
                  cfg_reg[7:0] : wr_lo_reg};
    end
  end

  // Busy from a conversion start until the core reports its result
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_reg <= 1'b0;
      conv_start_reg <= 1'b0;
    end else if (por_reg) begin
      busy_reg <= por_end;
      conv_start_reg <= por_end;
    end else begin
      conv_start_reg <= kick && !busy_reg;
      if (kick && !busy_reg) begin
        busy_reg <= 1'b1;
      end else if (conv_done_i) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // Result word: sign flag, two's complement value, six zero pad bits
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_reg <= '0;
    end else if (por_reg) begin
      hold_reg <= '0;
    end else if (conv_done_i && busy_reg) begin
      if (over_i) begin
        hold_reg <= {`ADS_OVR_CODE, `ADS_PAD_ZERO};
      end else if (under_i) begin
        hold_reg <= {`ADS_UNR_CODE, `ADS_PAD_ZERO};
      end else begin
        hold_reg <= {~result_i[16], result_i, `ADS_PAD_ZERO};
      end
    end
  end

  assign bus.dev_sda_o = sda_o_reg;
  assign bus.dev_sda_oe_n = sda_oe_n_reg;
  assign conv_start_o = conv_start_reg;
  assign cfg_o = cfg_reg;
  assign busy_o = busy_reg;
  assign por_o = por_reg;

endmodule : ads_dev_end

// >>> rtl/ads_host_end.sv
/*
  Controller end of the two-wire serial port: generates clock, Start,
  Repeated Start and Stop, shifts address, write words and read bytes.
  Assumes one command at a time on the user side, taken while ready_o.
*/
`timescale 1ns/10ps
`include "ads_consts.svh"
module ads_host_end
  import ads_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  ads_if.host bus,
  input wire logic cmd_valid_i,
  input wire logic cmd_read_i,
  input wire logic [1:0] cmd_len_i,
  input wire logic cmd_hold_i,
  input wire logic [6:0] addr_i,
  input wire logic [15:0] wr_data_i,
  output logic ready_o,
  output logic done_o,
  output logic nak_o,
  output logic [23:0] rd_data_o
);

  logic [2:0] sda_sy_reg;
  logic sda_reg;
  ads_host_state_type state_reg;
  logic [`ADS_QTR_W-1:0] qcnt_reg;
  logic tick;
  logic [1:0] ph_reg;
  logic [3:0] bit_reg;
  logic [1:0] byte_reg;
  logic [1:0] len_reg;
  logic rd_reg;
  logic hold_reg;
  logic [7:0] tx_reg;
  logic [15:0] wd_reg;
  logic [23:0] rdat_reg;
  logic nak_reg;
  logic done_reg;
  logic ready_reg;
  logic scl_reg;
  logic sda_oe_n_reg;
  logic sda_o_reg;
  logic rx_byte;

  // Data line sampled through three stages; changes when last two agree
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sda_sy_reg <= 3'h7;
      sda_reg <= 1'b1;
    end else begin
      sda_sy_reg <= {sda_sy_reg[1:0], bus.sda};
      if (sda_sy_reg[1] == sda_sy_reg[2]) begin
        sda_reg <= sda_sy_reg[2];
      end
    end
  end

  // Quarter-bit timebase; standard mode keeps margin under the fast limit
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      qcnt_reg <= '0;
    end else if (tick || state_reg == HS_IDLE || state_reg == HS_HELD) begin
      qcnt_reg <= '0;
    end else begin
      qcnt_reg <= qcnt_reg + 1'b1;
    end
  end

  assign tick = (qcnt_reg == `ADS_QTR_W'(`ADS_QTR_CYC - 1));
  // Data bytes of a read come from the converter
  assign rx_byte = rd_reg && byte_reg != `ADS_LEN_ADDR;

  // Sequencer: clock low, data set, clock high, sample, once per quarter
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= HS_IDLE;
      ph_reg <= '0;
      bit_reg <= '0;
      byte_reg <= '0;
      len_reg <= '0;
      rd_reg <= 1'b0;
      hold_reg <= 1'b0;
      tx_reg <= '0;
      wd_reg <= '0;
      rdat_reg <= '0;
      nak_reg <= 1'b0;
      done_reg <= 1'b0;
      ready_reg <= 1'b1;
      scl_reg <= 1'b1;
      sda_oe_n_reg <= 1'b1;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        HS_IDLE, HS_HELD: begin
          if (cmd_valid_i) begin
            state_reg <= HS_START;
            ph_reg <= '0;
            rd_reg <= cmd_read_i;
            len_reg <= cmd_len_i;
            hold_reg <= cmd_hold_i;
            tx_reg <= {addr_i, cmd_read_i};
            wd_reg <= wr_data_i;
            nak_reg <= 1'b0;
            ready_reg <= 1'b0;
          end
        end
        HS_START: begin
          if (tick) begin
            ph_reg <= ph_reg + 1'b1;
            case (ph_reg)
              2'h0: scl_reg <= 1'b0;
              2'h1: sda_oe_n_reg <= 1'b1;
              2'h2: scl_reg <= 1'b1;
              default: begin
                sda_oe_n_reg <= 1'b0;
                bit_reg <= '0;
                byte_reg <= '0;
                state_reg <= HS_BIT;
              end
            endcase
          end
        end
        HS_BIT: begin
          if (tick) begin
            ph_reg <= ph_reg + 1'b1;
            case (ph_reg)
              2'h0: scl_reg <= 1'b0;
              2'h1: begin
                if (bit_reg != `ADS_ACK_SLOT) begin
                  sda_oe_n_reg <= rx_byte ? 1'b1 : tx_reg[7];
                end else if (rx_byte) begin
                  sda_oe_n_reg <= (byte_reg == len_reg); // Refuse the last
                end else begin
                  sda_oe_n_reg <= 1'b1;
                end
              end
              2'h2: scl_reg <= 1'b1;
              default: begin
                if (bit_reg != `ADS_ACK_SLOT) begin
                  if (rx_byte) begin
                    rdat_reg <= {rdat_reg[22:0], sda_reg};
                  end
                  tx_reg <= {tx_reg[6:0], 1'b0};
                  bit_reg <= bit_reg + 1'b1;
                end else if (!rx_byte && sda_reg) begin
                  nak_reg <= 1'b1;
                  state_reg <= HS_STOP;
                end else if (byte_reg == len_reg) begin
                  state_reg <= hold_reg ? HS_HELD : HS_STOP;
                  ready_reg <= hold_reg;
                  done_reg <= hold_reg;
                end else begin
                  bit_reg <= '0;
                  byte_reg <= byte_reg + 1'b1;
                  tx_reg <= (byte_reg == `ADS_LEN_ADDR) ?
                            wd_reg[15:8] : wd_reg[7:0];
                end
              end
            endcase
          end
        end
        HS_STOP: begin
          if (tick) begin
            ph_reg <= ph_reg + 1'b1;
            case (ph_reg)
              2'h0: scl_reg <= 1'b0;
              2'h1: sda_oe_n_reg <= 1'b0;
              2'h2: scl_reg <= 1'b1;
              default: begin
                sda_oe_n_reg <= 1'b1;
                state_reg <= HS_IDLE;
                done_reg <= 1'b1;
                ready_reg <= 1'b1;
              end
            endcase
          end
        end
        default: begin
          state_reg <= HS_IDLE;
          ready_reg <= 1'b1;
        end
      endcase
    end
  end

  // Data output level is always low; only the enable moves
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sda_o_reg <= 1'b0;
    end else begin
      sda_o_reg <= 1'b0;
    end
  end

  assign bus.scl = scl_reg;
  assign bus.host_sda_o = sda_o_reg;
  assign bus.host_sda_oe_n = sda_oe_n_reg;
  assign ready_o = ready_reg;
  assign done_o = done_reg;
  assign nak_o = nak_reg;
  assign rd_data_o = rdat_reg;

endmodule : ads_host_end

// >>> verif/ads_sva.sv
/*
  Checker for the two-wire bus joining both ends of the port.
  Assumes it is instantiated beside the interface, fed its signals.
*/
`timescale 1ns/10ps
module ads_sva (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_n
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic scl_reg;
  logic [7:0] hold_reg;

  // Cycles since the clock line last moved; saturates to stay quiet
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_reg <= 1'b1;
      hold_reg <= 8'hFF;
    end else begin
      scl_reg <= scl;
      if (scl != scl_reg) hold_reg <= 8'h00;
      else if (hold_reg != 8'hFF) hold_reg <= hold_reg + 8'h01;
    end
  end

  property p_dev_zero; dev_sda_o == 1'b0; endproperty
  a_dev_zero: assert property (p_dev_zero)
    else $error("converter drives data line high");
  property p_host_zero; host_sda_o == 1'b0; endproperty
  a_host_zero: assert property (p_host_zero)
    else $error("controller drives data line high");
  property p_wire;
    sda == !((!dev_sda_oe_n && !dev_sda_o) || (!host_sda_oe_n && !host_sda_o));
  endproperty
  a_wire: assert property (p_wire)
    else $error("data line level not pull-up resolved");
  // Half period of 1.25 us at the fastest allowed rate
  property p_rate; $changed(scl) |-> hold_reg >= 8'h18; endproperty
  a_rate: assert property (p_rate)
    else $error("clock half period too short");
  property p_dev_scl_low; $changed(dev_sda_oe_n) |-> !scl; endproperty
  a_dev_scl_low: assert property (p_dev_scl_low)
    else $error("converter moved data while clock high");
  property p_dev_lag; $changed(dev_sda_oe_n) |-> $past(scl, 10); endproperty
  a_dev_lag: assert property (p_dev_lag)
    else $error("converter data change not tied to clock fall");
  property p_start;
    scl && $fell(host_sda_oe_n) |-> (scl && !sda) [*8];
  endproperty
  a_start: assert property (p_start)
    else $error("start condition malformed");
  property p_stop;
    scl && $rose(host_sda_oe_n) |-> (scl && sda) [*8];
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop condition malformed");

  c_ack: cover property ($fell(dev_sda_oe_n));
  c_start: cover property (scl && $fell(sda));
  c_stop: cover property (scl && $rose(sda));
endmodule : ads_sva

// >>> verif/adc_i2c_slave_port_bench.sv
/*
  Bench for both ends of the converter port joined by ads_if.
  Assumes package, constants header and checker are compiled first.
*/
`timescale 1ns/10ps
`include "ads_consts.svh"
module adc_i2c_slave_port_bench;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic supply_ok = 1'b1;
  logic conv_done = 1'b0;
  logic over = 1'b0;
  logic under = 1'b0;
  logic [16:0] result = 17'h00000;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic cmd_hold = 1'b0;
  logic [1:0] cmd_len = 2'h0;
  logic [6:0] addr = 7'h00;
  logic [15:0] wr_data = 16'h0000;
  logic conv_start, busy, por, ready, done, nak;
  logic [15:0] cfg;
  logic [23:0] rd_data;
  logic [16:0] r;
  logic [15:0] w;
  logic [15:0] exp_cfg = 16'hA000;
  logic [23:0] exp_rd;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  int kicks = 0;
  int seed = 76;

  ads_if bus_if ();
  // Short internal reset keeps the run brief
  ads_dev_end #(.POR_CYCLES(17'h00014)) i_ads_dev_end (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .bus(bus_if),
    .supply_ok_i(supply_ok), .conv_done_i(conv_done), .result_i(result),
    .over_i(over), .under_i(under), .conv_start_o(conv_start),
    .cfg_o(cfg), .busy_o(busy), .por_o(por));
  ads_host_end i_ads_host_end (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .bus(bus_if),
    .cmd_valid_i(cmd_valid), .cmd_read_i(cmd_read), .cmd_len_i(cmd_len),
    .cmd_hold_i(cmd_hold), .addr_i(addr), .wr_data_i(wr_data),
    .ready_o(ready), .done_o(done), .nak_o(nak), .rd_data_o(rd_data));
  ads_sva u_sva (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .scl(bus_if.scl),
    .sda(bus_if.sda), .dev_sda_o(bus_if.dev_sda_o),
    .dev_sda_oe_n(bus_if.dev_sda_oe_n), .host_sda_o(bus_if.host_sda_o),
    .host_sda_oe_n(bus_if.host_sda_oe_n));

  // Clock of 50 ns
  always #25 sys_clk_i = ~sys_clk_i;

  // Count conversion starts; a pulse lasts one cycle
  always @(posedge sys_clk_i) begin
    if (conv_start === 1'b1) kicks <= kicks + 1;
  end

  // Hang guard, well above the expected length of the run
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 80000) begin
      failures++;
      final_report();
    end
  end

  // Expected result word: status bits, value, zero padding
  function automatic logic [23:0] fmt(input logic [16:0] v, input logic o,
                                      input logic u);
    if (o) return 24'hC00000;
    if (u) return 24'h3FFFC0;
    return {~v[16], v, 6'h00};
  endfunction : fmt

  task chk(input logic [23:0] g, input logic [23:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task final_report();
    $display("comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report

  // One command; request is held for the single edge that takes it
  task xfer(input logic rd, input logic [1:0] len, input logic hold,
            input logic [6:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_len <= len;
    cmd_hold <= hold;
    addr <= a;
    wr_data <= d;
    @(posedge sys_clk_i);
    cmd_valid <= 1'b0;
    #1;
    while (done !== 1'b1) @(posedge sys_clk_i) #1;
  endtask : xfer

  // Conversion core finishes: mode 0 in range, 1 over, 2 under
  task pulse(input int mode);
    @(posedge sys_clk_i);
    r = 17'($random(seed));
    conv_done <= 1'b1;
    result <= r;
    over <= (mode == 1);
    under <= (mode == 2);
    exp_rd = fmt(r, mode == 1, mode == 2);
    @(posedge sys_clk_i);
    conv_done <= 1'b0;
  endtask : pulse

  // The start pulse is counted one edge after it is launched
  task wait_por();
    while (por !== 1'b0) @(posedge sys_clk_i) #1;
    @(posedge sys_clk_i) #1;
  endtask : wait_por

  task wait_busy();
    while (busy !== 1'b1) @(posedge sys_clk_i) #1;
    @(posedge sys_clk_i) #1;
  endtask : wait_busy

  // Main sequence
  initial begin
    repeat (16) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    #1;
    chk({23'h0, por}, 24'h1);
    chk({8'h0, cfg}, {8'h0, `ADS_CFG_RST});
    wait_por();
    chk(kicks[23:0], 24'h1);
    // Still converting: both directions refused
    for (int i = 0; i < 2; i++) begin
      xfer(i[0], 2'h1, 1'b0, `ADS_DEV_ADDR, 16'h0000);
      chk({23'h0, nak}, 24'h1);
    end
    // Write both words, then one byte read after a repeated start
    for (int i = 0; i < 2; i++) begin
      pulse(0);
      w = 16'($random(seed));
      w[15:13] = i ? 3'h4 : 3'h5;
      if (i == 0) exp_cfg = w;
      xfer(1'b0, 2'h2, 1'b1, `ADS_DEV_ADDR, w);
      chk({23'h0, nak}, 24'h0);
      xfer(1'b1, 2'h1, 1'b0, `ADS_DEV_ADDR, 16'h0000);
      chk({16'h0, rd_data[7:0]}, {16'h0, exp_rd[23:16]});
      wait_busy();
      chk({8'h0, cfg}, {8'h0, exp_cfg});
      chk(kicks[23:0], 24'(i + 2));
    end
    // Full reads of in-range, overrange and underrange results
    for (int k = 0; k < 3; k++) begin
      pulse(k);
      if (k == 0) begin
        xfer(1'b1, 2'h3, 1'b0, `ADS_DEV_ADDR ^ 7'h01, 16'h0000);
        chk({23'h0, nak}, 24'h1);
      end
      xfer(1'b1, 2'h3, 1'b0, `ADS_DEV_ADDR, 16'h0000);
      chk(rd_data, exp_rd);
      wait_busy();
      chk(kicks[23:0], 24'(k + 4));
    end
    // Single written word keeps the previous mode word
    pulse(0);
    w = 16'($random(seed));
    w[15:13] = 3'h5;
    exp_cfg = {w[15:8], exp_cfg[7:0]};
    xfer(1'b0, 2'h1, 1'b0, `ADS_DEV_ADDR, w);
    chk({23'h0, ready}, 24'h1);
    wait_busy();
    chk({8'h0, cfg}, {8'h0, exp_cfg});
    chk(kicks[23:0], 24'h7);
    // Supply dip clears the written setting and restarts
    @(posedge sys_clk_i);
    supply_ok <= 1'b0;
    while (por !== 1'b1) @(posedge sys_clk_i) #1;
    // Defaults load one edge after the internal reset rises
    @(posedge sys_clk_i) #1;
    chk({8'h0, cfg}, {8'h0, `ADS_CFG_RST});
    @(posedge sys_clk_i);
    supply_ok <= 1'b1;
    wait_por();
    chk(kicks[23:0], 24'h8);
    final_report();
  end
endmodule : adc_i2c_slave_port_bench
